// ===== rtl/phy_lp_pkg.sv
// Purpose: Shared constants and carriers for the low-power control registers
// Assumes: Register addresses are 5-bit management register numbers
// Notes:   All register resets are zero except ENERGY_RESET, which resets the energy synchroniser to one
package phy_lp_pkg;

  localparam logic [4:0]  ADDR_CTRL_ZERO         = 5'h11;
  localparam logic [4:0]  ADDR_CTRL_TWO          = 5'h13;
  localparam logic [4:0]  ADDR_CTRL_THREE        = 5'h14;
  localparam logic [15:0] REG_RESET              = 16'h0000;
  localparam logic        ENERGY_RESET           = 1'b1;
  localparam int          CTRL_ZERO_SLOW_OSC_BIT = 6;
  localparam int          CTRL_TWO_HI_THRESH_BIT = 15;
  localparam int          CTRL_TWO_SLEEP_OSC_BIT = 0;
  localparam int          CTRL_TWO_KEEP_HI_MSB   = 9;
  localparam int          CTRL_TWO_KEEP_HI_LSB   = 8;
  localparam int          CTRL_TWO_KEEP_LO_MSB   = 1;
  localparam int          CTRL_TWO_KEEP_LO_LSB   = 0;
  localparam int          CTRL_THREE_METHOD_BIT  = 6;
  localparam int          CTRL_THREE_MANUAL_BIT  = 5;
  localparam int          CTRL_THREE_RETAIN_BIT  = 4;
  localparam int          RETAIN_W           = 20;
  localparam logic [RETAIN_W-1:0] RETAIN_RESET = 20'h00000;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic slow_osc_pd;
    logic hi_thresh_en;
    logic slow_osc_sleep;
    logic deep_sleep;
  } lp_ctrl_t;

  typedef enum logic {ST_AWAKE, ST_SLEEP} sleep_state_t;

endpackage

// ===== rtl/retained_store.sv
// Purpose: Retained copy of selected control bits
// Assumes: Captures every cycle while enabled
// Notes:   Read data comes from a register and reads zero while disabled
`timescale 1ns/1ps
`default_nettype none
module retained_store
  import phy_lp_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                en,
  input  wire logic [RETAIN_W-1:0] din,
  output logic      [RETAIN_W-1:0] dout
);

  logic [RETAIN_W-1:0] mem_r;
  logic [RETAIN_W-1:0] mem_nxt;
  logic [RETAIN_W-1:0] dout_nxt;

  always_comb
  begin
    mem_nxt  = en ? din : mem_r;
    dout_nxt = en ? mem_r : RETAIN_RESET;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_r <= RETAIN_RESET;
      dout  <= RETAIN_RESET;
    end
    else
    begin
      mem_r <= mem_nxt;
      dout  <= dout_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/phy_low_power_control_regs.sv
// Purpose: Low-power and diagnostic control registers of the transceiver
// Assumes: Management frames are decoded upstream into one-cycle requests
// Notes:   Deepest sleep is left only through arst_n
`timescale 1ns/1ps
`default_nettype none
module phy_low_power_control_regs
  import phy_lp_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire mgmt_req_t           req,
  input  wire logic                power_down,
  input  wire logic                cable_energy,
  output logic      [15:0]         rd_data,
  output logic                     rd_valid,
  output lp_ctrl_t                 ctrl,
  output logic      [RETAIN_W-1:0] retained
);

  logic [15:0]         analog_control_zero_r;
  logic [15:0]         analog_control_zero_nxt;
  logic [15:0]         analog_control_two_r;
  logic [15:0]         analog_control_two_nxt;
  logic [15:0]         analog_control_three_r;
  logic [15:0]         analog_control_three_nxt;
  logic [15:0]         rd_data_nxt;
  logic                rd_valid_nxt;
  logic                energy_s1_r;
  logic                energy_s2_r;
  sleep_state_t        state_r;
  sleep_state_t        state_nxt;
  lp_ctrl_t            ctrl_nxt;
  logic                sleep_req;
  logic [RETAIN_W-1:0] retain_din;

  function automatic logic hit(input mgmt_req_t r, input logic [4:0] a);
    return r.addr == a;
  endfunction

  // Reserved fields are plain storage so software sees back what it wrote
  always_comb
  begin
    analog_control_zero_nxt  = analog_control_zero_r;
    analog_control_two_nxt   = analog_control_two_r;
    analog_control_three_nxt = analog_control_three_r;
    rd_data_nxt              = REG_RESET;
    rd_valid_nxt             = req.rd;
    if (req.wr && hit(req, ADDR_CTRL_ZERO))
      analog_control_zero_nxt = req.wdata;
    if (req.wr && hit(req, ADDR_CTRL_TWO))
      analog_control_two_nxt = req.wdata;
    if (req.wr && hit(req, ADDR_CTRL_THREE))
      analog_control_three_nxt = req.wdata;
    if (req.rd)
    begin
      if (hit(req, ADDR_CTRL_ZERO))
        rd_data_nxt = analog_control_zero_r;
      else if (hit(req, ADDR_CTRL_TWO))
        rd_data_nxt = analog_control_two_r;
      else if (hit(req, ADDR_CTRL_THREE))
        rd_data_nxt = analog_control_three_r;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      analog_control_zero_r  <= REG_RESET;
      analog_control_two_r   <= REG_RESET;
      analog_control_three_r <= REG_RESET;
      rd_data                <= REG_RESET;
      rd_valid               <= 1'b0;
    end
    else
    begin
      analog_control_zero_r  <= analog_control_zero_nxt;
      analog_control_two_r   <= analog_control_two_nxt;
      analog_control_three_r <= analog_control_three_nxt;
      rd_data                <= rd_data_nxt;
      rd_valid               <= rd_valid_nxt;
    end
  end

  // Cable energy is a pin, so it is synchronised before use
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Resets to energy present so that a reset alone never looks like a lost cable
      energy_s1_r <= ENERGY_RESET;
      energy_s2_r <= ENERGY_RESET;
    end
    else
    begin
      energy_s1_r <= cable_energy;
      energy_s2_r <= energy_s1_r;
    end
  end

  // Method bit picks the sleep source; once asleep only arst_n leaves
  always_comb
  begin
    if (analog_control_three_r[CTRL_THREE_METHOD_BIT])
      sleep_req = analog_control_three_r[CTRL_THREE_MANUAL_BIT];
    else
      sleep_req = !energy_s2_r;
    state_nxt = state_r;
    case (state_r)
      ST_AWAKE:
        if (sleep_req)
          state_nxt = ST_SLEEP;
      ST_SLEEP:
        state_nxt = ST_SLEEP;
      default:
        state_nxt = ST_AWAKE;
    endcase
    ctrl_nxt.slow_osc_pd    = analog_control_zero_r[CTRL_ZERO_SLOW_OSC_BIT] & power_down;
    ctrl_nxt.hi_thresh_en   = analog_control_two_r[CTRL_TWO_HI_THRESH_BIT];
    ctrl_nxt.slow_osc_sleep = analog_control_two_r[CTRL_TWO_SLEEP_OSC_BIT] & (state_r == ST_SLEEP);
    ctrl_nxt.deep_sleep     = (state_r == ST_SLEEP);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_AWAKE;
      ctrl    <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      ctrl    <= ctrl_nxt;
    end
  end

  // Retained copy tracks the live bits only while enabled
  assign retain_din = {analog_control_three_r,
                       analog_control_two_r[CTRL_TWO_KEEP_HI_MSB:CTRL_TWO_KEEP_HI_LSB],
                       analog_control_two_r[CTRL_TWO_KEEP_LO_MSB:CTRL_TWO_KEEP_LO_LSB]};

  retained_store i_retained_store (
    .clk    (clk),
    .arst_n (arst_n),
    .en     (analog_control_three_r[CTRL_THREE_RETAIN_BIT]),
    .din    (retain_din),
    .dout   (retained)
  );

  sequence s_wr_three;
    req.wr && req.addr == ADDR_CTRL_THREE;
  endsequence

  sequence s_wr_two;
    req.wr && req.addr == ADDR_CTRL_TWO;
  endsequence

  sequence s_rd_three;
    req.rd && req.addr == ADDR_CTRL_THREE && !req.wr;
  endsequence

  chk_slow_osc_pd: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl.slow_osc_pd == ($past(analog_control_zero_r[CTRL_ZERO_SLOW_OSC_BIT]) && $past(power_down)))
    else $error("slow oscillator power-down select wrong");

  chk_thresh_follow: assert property (@(posedge clk) disable iff (!arst_n)
    s_wr_two |-> ##2 ctrl.hi_thresh_en == $past(req.wdata[CTRL_TWO_HI_THRESH_BIT], 2))
    else $error("high threshold enable does not follow write");

  chk_sleep_osc: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl.slow_osc_sleep |-> ctrl.deep_sleep && $past(analog_control_two_r[CTRL_TWO_SLEEP_OSC_BIT]))
    else $error("sleep oscillator active outside sleep or disabled");

  chk_sleep_osc_off: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == ST_SLEEP && !analog_control_two_r[CTRL_TWO_SLEEP_OSC_BIT]) |=> !ctrl.slow_osc_sleep)
    else $error("sleep oscillator active while its bit is clear");

  chk_auto_entry: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == ST_AWAKE && !analog_control_three_r[CTRL_THREE_METHOD_BIT] && !energy_s2_r)
    |-> ##2 ctrl.deep_sleep)
    else $error("automatic sleep not entered on lost energy");

  chk_auto_ignore: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == ST_AWAKE && !analog_control_three_r[CTRL_THREE_METHOD_BIT] && energy_s2_r)
    |=> state_r == ST_AWAKE)
    else $error("sleep entered under automatic method with energy present");

  chk_manual_entry: assert property (@(posedge clk) disable iff (!arst_n)
    (analog_control_three_r[CTRL_THREE_METHOD_BIT] && analog_control_three_r[CTRL_THREE_MANUAL_BIT])
    |-> ##2 ctrl.deep_sleep)
    else $error("manual sleep request not honoured");

  chk_manual_gate: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == ST_AWAKE && analog_control_three_r[CTRL_THREE_METHOD_BIT]
     && !analog_control_three_r[CTRL_THREE_MANUAL_BIT]) |=> state_r == ST_AWAKE)
    else $error("sleep entered without manual request");

  chk_no_wake: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl.deep_sleep |=> ctrl.deep_sleep [*4])
    else $error("left deep sleep without reset");

  // Store lags the live bits by two edges: capture, then registered read
  chk_retain_copy: assert property (@(posedge clk) disable iff (!arst_n)
    (s_wr_three ##1 analog_control_three_r[CTRL_THREE_RETAIN_BIT] [*3]) |-> retained == $past(retain_din, 2))
    else $error("retained copy does not hold the selected bits");

  chk_retain_off: assert property (@(posedge clk) disable iff (!arst_n)
    !analog_control_three_r[CTRL_THREE_RETAIN_BIT] |=> retained == RETAIN_RESET)
    else $error("retained copy visible while disabled");

  chk_reserved_rb: assert property (@(posedge clk) disable iff (!arst_n)
    (s_wr_three ##1 s_rd_three) |=> rd_valid && rd_data == $past(req.wdata, 2))
    else $error("register 14h read back differs from write");

endmodule
`default_nettype wire

// ===== tb/phy_low_power_control_regs_test.sv
// Purpose: Self-checking bench for the low-power control registers
// Assumes: Inputs change on the falling clock edge
// Notes:   cable_energy is held high except where a test needs no energy
`timescale 1ns/1ps
`default_nettype none
module phy_low_power_control_regs_test
  import phy_lp_pkg::*;
;
  logic                clk;
  logic                arst_n;
  mgmt_req_t           req;
  logic                power_down;
  logic                cable_energy;
  logic [15:0]         rd_data;
  logic                rd_valid;
  lp_ctrl_t            ctrl;
  logic [RETAIN_W-1:0] retained;
  int                  errors;
  int                  comparisons;

  phy_low_power_control_regs i_phy_low_power_control_regs (
    .clk(clk), .arst_n(arst_n), .req(req), .power_down(power_down), .cable_energy(cable_energy),
    .rd_data(rd_data), .rd_valid(rd_valid), .ctrl(ctrl), .retained(retained));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict;
    $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_ret(input logic [RETAIN_W-1:0] got, input logic [RETAIN_W-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: retained got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Strobes last exactly one cycle, so every request is taken once
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk);
    req = '0;
    cmp_bit(rd_valid, 1'b1, "rd_valid");
    cmp_word(rd_data, exp, "rd_data");
  endtask

  // Write then read in the very next cycle, as back-to-back requests are allowed
  task automatic wr_rd_chk(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk);
    req = '0;
    cmp_bit(rd_valid, 1'b1, "rd_valid");
    cmp_word(rd_data, d, "rd_data");
  endtask

  // Energy stays present through reset so the automatic method keeps the block awake
  task automatic do_reset;
    @(negedge clk);
    cable_energy = 1'b1;
    arst_n = 1'b0;
    cycles(5);
    arst_n = 1'b1;
  endtask

  task automatic t_reset;
    logic [4:0] addrs [4];
    addrs = '{ADDR_CTRL_ZERO, ADDR_CTRL_TWO, ADDR_CTRL_THREE, 5'h12};
    foreach (addrs[i]) rd_chk(addrs[i], REG_RESET);
    cmp_ret(retained, RETAIN_RESET);
    $display("t_reset done");
  endtask

  task automatic t_readback;
    wr(ADDR_CTRL_ZERO, 16'hFFBF);
    rd_chk(ADDR_CTRL_ZERO, 16'hFFBF);
    wr(ADDR_CTRL_TWO, 16'h7FFE);
    rd_chk(ADDR_CTRL_TWO, 16'h7FFE);
    wr(ADDR_CTRL_THREE, 16'hFF8F);
    rd_chk(ADDR_CTRL_THREE, 16'hFF8F);
    wr(5'h12, 16'hFFFF);
    rd_chk(5'h12, 16'h0000);
    wr_rd_chk(ADDR_CTRL_THREE, 16'hFF80);
    do_reset;
    $display("t_readback done");
  endtask

  task automatic t_osc_thresh;
    wr(ADDR_CTRL_ZERO, 16'h0040);
    power_down = 1'b1;
    cycles(3);
    cmp_bit(ctrl.slow_osc_pd, 1'b1, "slow_osc_pd");
    power_down = 1'b0;
    cycles(3);
    cmp_bit(ctrl.slow_osc_pd, 1'b0, "slow_osc_pd");
    wr(ADDR_CTRL_ZERO, 16'h0000);
    power_down = 1'b1;
    cycles(3);
    cmp_bit(ctrl.slow_osc_pd, 1'b0, "slow_osc_pd");
    power_down = 1'b0;
    wr(ADDR_CTRL_TWO, 16'h8000);
    cycles(2);
    cmp_bit(ctrl.hi_thresh_en, 1'b1, "hi_thresh_en");
    wr(ADDR_CTRL_TWO, 16'h0000);
    cycles(2);
    cmp_bit(ctrl.hi_thresh_en, 1'b0, "hi_thresh_en");
    $display("t_osc_thresh done");
  endtask

  task automatic t_retain;
    wr(ADDR_CTRL_TWO, 16'hA5A5);
    wr(ADDR_CTRL_THREE, 16'h1A50);
    cycles(4);
    cmp_ret(retained, {16'h1A50, 2'b01, 2'b01});
    wr(ADDR_CTRL_THREE, 16'h1A40);
    cycles(3);
    cmp_ret(retained, 20'h00000);
    do_reset;
    $display("t_retain done");
  endtask

  task automatic t_auto;
    wr(ADDR_CTRL_THREE, 16'h0020);
    cycles(5);
    cmp_bit(ctrl.deep_sleep, 1'b0, "deep_sleep");
    cable_energy = 1'b0;
    cycles(6);
    cmp_bit(ctrl.deep_sleep, 1'b1, "deep_sleep");
    cmp_bit(ctrl.slow_osc_sleep, 1'b0, "slow_osc_sleep");
    cable_energy = 1'b1;
    cycles(4);
    cmp_bit(ctrl.deep_sleep, 1'b1, "deep_sleep");
    do_reset;
    cycles(4);
    cmp_bit(ctrl.deep_sleep, 1'b0, "deep_sleep");
    $display("t_auto done");
  endtask

  task automatic t_manual;
    wr(ADDR_CTRL_TWO, 16'h0001);
    wr(ADDR_CTRL_THREE, 16'h0050);
    cable_energy = 1'b0;
    cycles(6);
    cmp_bit(ctrl.deep_sleep, 1'b0, "deep_sleep");
    cmp_bit(ctrl.slow_osc_sleep, 1'b0, "slow_osc_sleep");
    wr(ADDR_CTRL_THREE, 16'h0070);
    cycles(4);
    cmp_bit(ctrl.deep_sleep, 1'b1, "deep_sleep");
    cmp_bit(ctrl.slow_osc_sleep, 1'b1, "slow_osc_sleep");
    wr(ADDR_CTRL_THREE, 16'h0050);
    cycles(4);
    cmp_bit(ctrl.deep_sleep, 1'b1, "deep_sleep");
    do_reset;
    $display("t_manual done");
  endtask

  initial
  begin
    arst_n = 1'b0;
    req = '0;
    power_down = 1'b0;
    cable_energy = 1'b1;
    errors = 0;
    comparisons = 0;
    do_reset;
    t_reset;
    t_readback;
    t_osc_thresh;
    t_retain;
    t_auto;
    t_manual;
    give_verdict;
  end

  // The tests need under 150 cycles; ten thousand means a hang
  initial
  begin
    #200000;
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule
`default_nettype wire
